// file: verilog/cdt_params.svh
// constants for the data transfer decoder core
`ifndef CDT_PARAMS_SVH
`define CDT_PARAMS_SVH
`define CDT_RESET_PC     16'h8000
`define CDT_RESET_SP     16'h0000
`define CDT_RST_SHIFT    3
`define CDT_REG_B        3'h0
`define CDT_REG_C        3'h1
`define CDT_REG_D        3'h2
`define CDT_REG_E        3'h3
`define CDT_REG_H        3'h4
`define CDT_REG_L        3'h5
`define CDT_REG_M        3'h6
`define CDT_REG_A        3'h7
`define CDT_PAIR_BC      2'h0
`define CDT_PAIR_DE      2'h1
`define CDT_PAIR_HL      2'h2
`define CDT_PAIR_SP      2'h3
`define CDT_OP_STA       8'h32
`define CDT_OP_LDA       8'h3A
`define CDT_OP_HL_PAIR_DIRECT_LOAD      8'h2A
`define CDT_OP_MVI_M     8'h36
`define CDT_OP_MOV_TO_M  5'h0E
`define CDT_OP_RST_MASK  8'hC7
`define CDT_OP_RST       8'hC7
`define CDT_STATES_REG   5
`define CDT_STATES_MEM   9
`define CDT_STATES_MVIM  13
`define CDT_STATES_DIR   17
`define CDT_STATES_HL_PAIR_DIRECT_LOAD  21
`define CDT_FLAG_S       7
`define CDT_FLAG_Z       6
`define CDT_FLAG_AC      4
`define CDT_FLAG_P       2
`define CDT_FLAG_CY      0
`endif

// file: verilog/cdt_pkg.sv
// types shared by the data transfer decoder core
package cdt_pkg;
  typedef enum logic [3:0] {
    CDT_FETCH = 4'h0,
    CDT_DECODE = 4'h1,
    CDT_OPND1 = 4'h3,
    CDT_OPND2 = 4'h2,
    CDT_MEMRD = 4'h6,
    CDT_MEMRD2 = 4'h7,
    CDT_MEMWR = 4'h5,
    CDT_WAIT = 4'h4,
    CDT_HALT = 4'hC
  } cdt_state_e;

  typedef struct packed {
    logic [15:0] addr;
    logic [7:0]  wdata;
    logic        rd;
    logic        wr;
  } cdt_mem_req_s;

  typedef struct packed {
    logic s;
    logic z;
    logic ac;
    logic p;
    logic cy;
  } cdt_flags_s;
endpackage

// file: verilog/cdt_core.sv
// fetch, decode and data transfer execution of the 8-bit core
`timescale 1ns/100ps
`include "cdt_params.svh"

// Notes on behaviour
// - opcode address is instruction address
// - multi-byte operands low byte first
// - direct address: byte2 low, byte3 high
// - indirect: first pair register high
// - immediate bytes follow the opcode
// - next fetch follows last byte
// - restart target is vector times eight
// - zero flag set on zero result
// - sign flag copies result top bit
// - parity flag set on even ones
// - carry flag on carry or borrow
// - half carry from bit three
// - three-bit register field encoding
// - two-bit pair field encoding
// - data transfers leave flags alone
// - register copy one cycle five states
// - memory read into register, nine states
// - register write to memory at HL
// - immediate load copies second byte
// - immediate store to HL, thirteen states
// - pair load: byte3 high, byte2 low
// - direct accumulator transfer, seventeen states
// - direct HL load: L then H
module cdt_core #(
  parameter int STATE_CYCLES = 1
) (
  input  wire logic        clk_i,       // 25 MHz clock
  input  wire logic        sys_rst_i,   // sync reset, active high
  output cdt_pkg::cdt_mem_req_s mem_o,  // memory request
  input  wire logic [7:0]  mem_rdata_i, // read data
  input  wire logic        mem_ack_i,   // access done
  input  wire cdt_pkg::cdt_flags_s alu_flags_i, // flags from outside ALU
  input  wire logic        alu_flags_we_i, // flag load strobe
  input  wire logic [7:0]  alu_result_i, // result for flag forming
  input  wire logic        alu_cout_i,  // carry/borrow out of bit 7
  input  wire logic        alu_hout_i,  // carry out of bit 3
  input  wire logic        alu_calc_i,  // form flags from result
  output logic [15:0]      pc_o,        // program counter
  output logic [15:0]      sp_o,        // stack pointer
  output logic [7:0]       acc_o,       // accumulator
  output cdt_pkg::cdt_flags_s flags_o,  // condition flags
  output logic [7:0]       opcode_o,    // current opcode
  output logic [4:0]       states_o,    // state count of last instruction
  output logic             retire_o,    // instruction done pulse
  output logic             unsupported_o // opcode other than copy, MVI, LXI, LDA, STA, direct HL load or RST seen
);
  if (STATE_CYCLES < 1 || STATE_CYCLES > 65536) begin : g_bad_cycles
    $error("STATE_CYCLES must lie between 1 and 65536");
  end

  cdt_pkg::cdt_state_e state_reg, state_next;
  logic [7:0]  regs_reg [0:7];
  logic [15:0] pc_reg, sp_reg, inst_pc_reg;
  logic [7:0]  op_reg, b2_reg, b3_reg;
  cdt_pkg::cdt_flags_s flags_reg;
  logic [4:0]  states_reg;
  logic        retire_reg, unsup_reg;
  cdt_pkg::cdt_mem_req_s mem_reg;

  function automatic logic [15:0] pair_val(input logic [1:0] sel,
                                           input logic [7:0] r [0:7],
                                           input logic [15:0] sp);
    case (sel)
      `CDT_PAIR_BC: pair_val = {r[`CDT_REG_B], r[`CDT_REG_C]};
      `CDT_PAIR_DE: pair_val = {r[`CDT_REG_D], r[`CDT_REG_E]};
      `CDT_PAIR_HL: pair_val = {r[`CDT_REG_H], r[`CDT_REG_L]};
      default:      pair_val = sp;
    endcase
  endfunction

  wire [1:0]  op_hi    = op_reg[7:6];
  wire [2:0]  dst_f    = op_reg[5:3]; // dest_reg_field
  wire [2:0]  src_f    = op_reg[2:0]; // src_reg_field
  wire [1:0]  pair_f   = op_reg[5:4]; // pair_select_field
  wire [15:0] hl_addr  = pair_val(`CDT_PAIR_HL, regs_reg, sp_reg);
  wire [15:0] dir_addr = {b3_reg, b2_reg};
  wire is_copy   = (op_hi == 2'h1) && !(dst_f == `CDT_REG_M && src_f == `CDT_REG_M);
  wire is_from_m = is_copy && (src_f == `CDT_REG_M);
  wire is_to_m   = is_copy && (op_reg[7:3] == `CDT_OP_MOV_TO_M);
  wire is_mvi    = (op_hi == 2'h0) && (src_f == 3'h6);
  wire is_lxi    = (op_hi == 2'h0) && (op_reg[3:0] == 4'h1);
  wire is_lda    = op_reg == `CDT_OP_LDA;
  wire is_sta    = op_reg == `CDT_OP_STA;
  wire is_hl_pair_direct_load   = op_reg == `CDT_OP_HL_PAIR_DIRECT_LOAD;
  wire is_rst    = (op_reg & `CDT_OP_RST_MASK) == `CDT_OP_RST;
  wire [1:0] n_opnd = (is_lxi || is_lda || is_sta || is_hl_pair_direct_load) ? 2'h2 :
                      is_mvi ? 2'h1 : 2'h0;
  wire known = is_copy || is_mvi || is_lxi || is_lda || is_sta || is_hl_pair_direct_load || is_rst;
  wire [15:0] rst_tgt = {10'h000, dst_f, 3'h0};
  wire [4:0] st_cnt = is_hl_pair_direct_load ? 5'(`CDT_STATES_HL_PAIR_DIRECT_LOAD) :
                      (is_lda || is_sta) ? 5'(`CDT_STATES_DIR) :
                      (is_mvi && dst_f == `CDT_REG_M) ? 5'(`CDT_STATES_MVIM) :
                      (is_from_m || is_to_m || is_mvi) ? 5'(`CDT_STATES_MEM) :
                      5'(`CDT_STATES_REG);
  wire par_even = ~^alu_result_i;
  logic [15:0] wait_cnt_reg;
  wire wait_done = wait_cnt_reg == 16'(STATE_CYCLES - 1);

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      cdt_pkg::CDT_FETCH:  if (mem_ack_i) state_next = cdt_pkg::CDT_DECODE;
      cdt_pkg::CDT_DECODE: begin
        if (!known) state_next = cdt_pkg::CDT_HALT;
        else if (n_opnd != 2'h0) state_next = cdt_pkg::CDT_OPND1;
        else if (is_from_m) state_next = cdt_pkg::CDT_MEMRD;
        else if (is_to_m) state_next = cdt_pkg::CDT_MEMWR;
        else state_next = cdt_pkg::CDT_WAIT;
      end
      cdt_pkg::CDT_OPND1: if (mem_ack_i) state_next =
        (n_opnd == 2'h2) ? cdt_pkg::CDT_OPND2 :
        (dst_f == `CDT_REG_M) ? cdt_pkg::CDT_MEMWR : cdt_pkg::CDT_WAIT;
      cdt_pkg::CDT_OPND2: if (mem_ack_i) state_next =
        (is_lda || is_hl_pair_direct_load) ? cdt_pkg::CDT_MEMRD :
        is_sta ? cdt_pkg::CDT_MEMWR : cdt_pkg::CDT_WAIT;
      cdt_pkg::CDT_MEMRD: if (mem_ack_i) state_next =
        is_hl_pair_direct_load ? cdt_pkg::CDT_MEMRD2 : cdt_pkg::CDT_WAIT;
      cdt_pkg::CDT_MEMRD2: if (mem_ack_i) state_next = cdt_pkg::CDT_WAIT;
      cdt_pkg::CDT_MEMWR: if (mem_ack_i) state_next = cdt_pkg::CDT_WAIT;
      cdt_pkg::CDT_WAIT:  if (wait_done) state_next = cdt_pkg::CDT_FETCH;
      default: state_next = cdt_pkg::CDT_HALT;
    endcase
  end

  // one byte per access, held until acknowledged
  always_comb begin
    mem_reg = '0;
    case (state_reg)
      cdt_pkg::CDT_FETCH: begin mem_reg.addr = pc_reg; mem_reg.rd = 1'b1; end
      cdt_pkg::CDT_OPND1, cdt_pkg::CDT_OPND2: begin
        mem_reg.addr = pc_reg;
        mem_reg.rd = 1'b1;
      end
      cdt_pkg::CDT_MEMRD: begin
        mem_reg.addr = (is_lda || is_hl_pair_direct_load) ? dir_addr : hl_addr;
        mem_reg.rd = 1'b1;
      end
      cdt_pkg::CDT_MEMRD2: begin
        mem_reg.addr = dir_addr + 16'h0001;
        mem_reg.rd = 1'b1;
      end
      cdt_pkg::CDT_MEMWR: begin
        mem_reg.addr = is_sta ? dir_addr : hl_addr;
        mem_reg.wdata = is_sta ? regs_reg[`CDT_REG_A] :
                        is_mvi ? b2_reg : regs_reg[src_f];
        mem_reg.wr = 1'b1;
      end
      default: ;
    endcase
  end
  assign mem_o = mem_reg;

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) state_reg <= cdt_pkg::CDT_FETCH;
    else state_reg <= state_next;
  end

  always_ff @(posedge clk_i) begin
    if (sys_rst_i || state_reg != cdt_pkg::CDT_WAIT) wait_cnt_reg <= 16'h0000;
    else wait_cnt_reg <= wait_cnt_reg + 16'h0001;
  end

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      pc_reg <= `CDT_RESET_PC;
      inst_pc_reg <= `CDT_RESET_PC;
      op_reg <= 8'h00;
      b2_reg <= 8'h00;
      b3_reg <= 8'h00;
    end else begin
      if (mem_ack_i && state_reg == cdt_pkg::CDT_FETCH) begin
        op_reg <= mem_rdata_i;
        inst_pc_reg <= pc_reg;
        pc_reg <= pc_reg + 16'h0001;
      end
      if (mem_ack_i && state_reg == cdt_pkg::CDT_OPND1) begin
        b2_reg <= mem_rdata_i;
        pc_reg <= pc_reg + 16'h0001;
      end
      if (mem_ack_i && state_reg == cdt_pkg::CDT_OPND2) begin
        b3_reg <= mem_rdata_i;
        pc_reg <= pc_reg + 16'h0001;
      end
      if (state_reg == cdt_pkg::CDT_DECODE && is_rst) pc_reg <= rst_tgt;
    end
  end

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) sp_reg <= `CDT_RESET_SP;
    else if (state_reg == cdt_pkg::CDT_OPND2 && mem_ack_i && is_lxi &&
             pair_f == `CDT_PAIR_SP) sp_reg <= {mem_rdata_i, b2_reg};
  end

  wire [7:0] reg_next [0:7];
  for (genvar g = 0; g < 8; g++) begin : g_regs
    if (g != 6) begin : g_real
      wire ld_copy = state_reg == cdt_pkg::CDT_DECODE && is_copy && !is_from_m &&
                     !is_to_m && dst_f == 3'(g);
      wire ld_mem  = state_reg == cdt_pkg::CDT_MEMRD && mem_ack_i &&
                     ((is_from_m && dst_f == 3'(g)) || (is_lda && g == 7) ||
                      (is_hl_pair_direct_load && g == 5));
      wire ld_hi   = state_reg == cdt_pkg::CDT_MEMRD2 && mem_ack_i && g == 4;
      wire ld_imm  = state_reg == cdt_pkg::CDT_OPND1 && mem_ack_i && is_mvi &&
                     dst_f == 3'(g);
      wire ld_plo  = state_reg == cdt_pkg::CDT_OPND1 && mem_ack_i && is_lxi &&
                     pair_f != `CDT_PAIR_SP && 3'(g) == {pair_f, 1'b1};
      wire ld_phi  = state_reg == cdt_pkg::CDT_OPND2 && mem_ack_i && is_lxi &&
                     pair_f != `CDT_PAIR_SP && 3'(g) == {pair_f, 1'b0};
      assign reg_next[g] = ld_copy ? regs_reg[src_f] :
                           (ld_mem || ld_hi || ld_imm || ld_plo || ld_phi) ? mem_rdata_i :
                           regs_reg[g];
    end else begin : g_none
      assign reg_next[g] = 8'h00;
    end
  end

  // one process owns the whole register file
  always_ff @(posedge clk_i) begin
    for (int i = 0; i < 8; i++) begin
      if (sys_rst_i) regs_reg[i] <= 8'h00;
      else regs_reg[i] <= reg_next[i];
    end
  end

  // flags change only on the outside strobe, never from a transfer
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) flags_reg <= '0;
    else if (alu_flags_we_i && alu_calc_i) begin
      flags_reg.z  <= alu_result_i == 8'h00;
      flags_reg.s  <= alu_result_i[7];
      flags_reg.p  <= par_even;
      flags_reg.cy <= alu_cout_i;
      flags_reg.ac <= alu_hout_i;
    end else if (alu_flags_we_i) flags_reg <= alu_flags_i;
  end

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      retire_reg <= 1'b0;
      states_reg <= 5'h00;
      unsup_reg <= 1'b0;
    end else begin
      retire_reg <= state_reg == cdt_pkg::CDT_WAIT && wait_done;
      if (state_reg == cdt_pkg::CDT_DECODE) states_reg <= st_cnt;
      if (state_reg == cdt_pkg::CDT_DECODE && !known) unsup_reg <= 1'b1;
    end
  end

  assign pc_o = pc_reg;
  assign sp_o = sp_reg;
  assign acc_o = regs_reg[`CDT_REG_A];
  assign flags_o = flags_reg;
  assign opcode_o = op_reg;
  assign states_o = states_reg;
  assign retire_o = retire_reg;
  assign unsupported_o = unsup_reg;

  chk_flags_hold: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    !alu_flags_we_i |=> flags_reg == $past(flags_reg))
    else $error("flags changed without strobe");
  chk_zero_flag: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    alu_flags_we_i && alu_calc_i |=> flags_reg.z == ($past(alu_result_i) == 8'h00))
    else $error("zero flag wrong");
  chk_parity_flag: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    alu_flags_we_i && alu_calc_i |=> flags_reg.p == ~^$past(alu_result_i))
    else $error("parity flag wrong");
  chk_sign_flag: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    alu_flags_we_i && alu_calc_i |=> flags_reg.s == $past(alu_result_i[7]))
    else $error("sign flag wrong");
  chk_rst_target: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    state_reg == cdt_pkg::CDT_DECODE && is_rst |=> pc_reg == {10'h000, $past(dst_f), 3'h0})
    else $error("restart target wrong");
  chk_fetch_step: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    state_reg == cdt_pkg::CDT_FETCH && mem_ack_i |=> pc_reg == $past(pc_reg) + 16'h0001)
    else $error("pc did not advance");
  chk_one_access: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    !(mem_o.rd && mem_o.wr))
    else $error("read and write together");
  chk_hl_write: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    state_reg == cdt_pkg::CDT_MEMWR && is_to_m |-> mem_o.addr == hl_addr)
    else $error("write not at HL");
  chk_hl_pair_direct_load_high: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    state_reg == cdt_pkg::CDT_MEMRD2 |-> mem_o.addr == dir_addr + 16'h0001)
    else $error("second byte address wrong");
  chk_req_held: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    (mem_o.rd || mem_o.wr) && !mem_ack_i |=> $stable(mem_o))
    else $error("request changed before ack");
  chk_inst_addr: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    state_reg == cdt_pkg::CDT_FETCH && mem_ack_i |=> inst_pc_reg == $past(mem_o.addr))
    else $error("instruction address not opcode address");
  cov_copy: cover property (@(posedge clk_i) state_reg == cdt_pkg::CDT_DECODE && is_copy);
  cov_hl_pair_direct_load: cover property (@(posedge clk_i) state_reg == cdt_pkg::CDT_MEMRD2 && mem_ack_i);
  cov_sta: cover property (@(posedge clk_i) state_reg == cdt_pkg::CDT_MEMWR && is_sta);
  cov_mvi_m: cover property (@(posedge clk_i) state_reg == cdt_pkg::CDT_MEMWR && is_mvi);
endmodule

// file: verif/cdt_mem_model.sv
// shared byte-wide memory with a varying answer time
`timescale 1ns/100ps
module cdt_mem_model (
  input  wire logic                 clk_i,   // system clock
  input  wire logic                 rst_i,   // sync reset, active high
  input  wire cdt_pkg::cdt_mem_req_s req_i,  // request from the core
  output logic [7:0]                rdata_o, // read data, valid with ack
  output logic                      ack_o    // one-cycle completion pulse
);
  logic [7:0]  mem [0:65535];
  logic [15:0] last_rd = 16'h0000;
  int          wait_cnt = 0;
  int          n_acc = 0;
  initial rdata_o = 8'h00;
  initial ack_o = 1'b0;
  // waits 0, 1 or 2 cycles in turn; data line toggles when not answering
  always @(posedge clk_i) begin
    ack_o <= 1'b0;
    rdata_o <= ~rdata_o;
    if (!rst_i && (req_i.rd || req_i.wr) && !ack_o) begin
      if (wait_cnt < n_acc % 3) begin
        wait_cnt <= wait_cnt + 1;
      end else begin
        wait_cnt <= 0;
        n_acc <= n_acc + 1;
        ack_o <= 1'b1;
        if (req_i.wr) begin
          mem[req_i.addr] <= req_i.wdata;
        end else begin
          rdata_o <= mem[req_i.addr];
          last_rd <= req_i.addr;
        end
      end
    end
  end
endmodule

// file: verif/test_cdt_core.sv
// self-checking bench for the data transfer core
`timescale 1ns/100ps
module test_cdt_core;
  logic clk_i = 1'b0;
  logic sys_rst_i = 1'b1;
  cdt_pkg::cdt_mem_req_s mem_req;
  cdt_pkg::cdt_flags_s   alu_flags = '0, flags_o;
  logic [7:0]  mem_rdata, alu_result = 8'h00, acc_o, opcode_o;
  logic        mem_ack, alu_we = 1'b0, alu_cout = 1'b0, alu_hout = 1'b0, alu_calc = 1'b0;
  logic [15:0] pc_o, sp_o, pa;
  logic [4:0]  states_o;
  logic        retire_o, unsupported_o;
  int          num_errors = 0, compares = 0, cycles = 0, n_ins = 0, n_ret = 0;

  cdt_core #(.STATE_CYCLES(1)) cdt_core_i (.clk_i(clk_i), .sys_rst_i(sys_rst_i),
    .mem_o(mem_req), .mem_rdata_i(mem_rdata), .mem_ack_i(mem_ack), .alu_flags_i(alu_flags),
    .alu_flags_we_i(alu_we), .alu_result_i(alu_result), .alu_cout_i(alu_cout),
    .alu_hout_i(alu_hout), .alu_calc_i(alu_calc), .pc_o(pc_o), .sp_o(sp_o), .acc_o(acc_o),
    .flags_o(flags_o), .opcode_o(opcode_o), .states_o(states_o), .retire_o(retire_o),
    .unsupported_o(unsupported_o));
  cdt_mem_model cdt_mem_model_i (.clk_i(clk_i), .rst_i(sys_rst_i), .req_i(mem_req),
    .rdata_o(mem_rdata), .ack_o(mem_ack));

  initial forever #20 clk_i = ~clk_i;

  task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
    compares++;
    if (got !== exp) begin
      $display("unexpected %s expected %h seen %h", nm, exp, got);
      num_errors++;
    end
  endtask

  task automatic final_report();
    $display("errors %0d compares %0d", num_errors, compares);
    if (num_errors == 0 && compares > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  always @(posedge clk_i) begin
    cycles++;
    if (cycles > 5000) begin
      num_errors++;
      final_report();
    end
  end

  function automatic int exp_states(input logic [7:0] op);
    if (op == 8'h36) return 13;
    if (op[7:6] == 2'b00 && op[2:0] == 3'h6) return 9;
    if (op == 8'h32 || op == 8'h3A) return 17;
    if (op[7:6] == 2'b01 && (op[2:0] == 3'h6 || op[5:3] == 3'h6)) return 9;
    if (op[7:6] == 2'b01) return 5;
    return 0;
  endfunction

  // state count checked at every finished instruction whose opcode exp_states knows (not LXI, RST or the direct HL load)
  always @(negedge clk_i) begin
    if (!sys_rst_i && retire_o === 1'b1) begin
      n_ret++;
      if (exp_states(opcode_o) != 0)
        chk("states", 16'(exp_states(opcode_o)), {11'h000, states_o});
    end
  end

  task automatic emit(input logic [7:0] b);
    cdt_mem_model_i.mem[pa] = b;
    pa++;
  endtask

  task automatic ins(input logic [7:0] b0, input int n, input logic [15:0] opnd);
    emit(b0);
    if (n > 0) emit(opnd[7:0]);
    if (n > 1) emit(opnd[15:8]);
    n_ins++;
  endtask

  task automatic build_program();
    pa = 16'h8000;
    for (int i = 0; i < 5; i++) begin
      logic [2:0] r;
      r = (i == 4) ? 3'h7 : 3'(i);
      ins(8'h21, 2, 16'h9000 + 16'(r));
      ins({2'b00, r, 3'b110}, 1, 16'h00A0 + 16'(r));
      ins({5'b01110, r}, 0, 16'h0000);
    end
    ins(8'h06, 1, 16'h003C);
    ins(8'h50, 0, 16'h0000);
    ins(8'h21, 2, 16'h9010);
    ins(8'h72, 0, 16'h0000);
    cdt_mem_model_i.mem[16'h9020] = 8'hC3;
    ins(8'h21, 2, 16'h9020);
    ins(8'h5E, 0, 16'h0000);
    ins(8'h21, 2, 16'h9021);
    ins(8'h73, 0, 16'h0000);
    ins(8'h21, 2, 16'h9030);
    ins(8'h36, 1, 16'h0077);
    ins(8'h32, 2, 16'h9040);
    cdt_mem_model_i.mem[16'h9050] = 8'h99;
    ins(8'h3A, 2, 16'h9050);
    cdt_mem_model_i.mem[16'h9060] = 8'h34;
    cdt_mem_model_i.mem[16'h9061] = 8'h12;
    ins(8'h2A, 2, 16'h9060);
    ins(8'h77, 0, 16'h0000);
    ins(8'h01, 2, 16'h5566);
    ins(8'h11, 2, 16'h7788);
    ins(8'h21, 2, 16'h9070);
    ins(8'h71, 0, 16'h0000);
    ins(8'h21, 2, 16'h9071);
    ins(8'h72, 0, 16'h0000);
    ins(8'h31, 2, 16'hBEEF);
    ins(8'hEF, 0, 16'h0000);
    cdt_mem_model_i.mem[16'h0028] = 8'h80;
  endtask

  task automatic flag_case(input logic calc, input logic [7:0] res, input logic c,
                           input logic h, input logic [4:0] ld);
    logic [4:0] exp;
    exp = calc ? {res[7], res == 8'h00, h, ~^res, c} : ld;
    @(negedge clk_i);
    {alu_we, alu_calc, alu_result, alu_cout, alu_hout, alu_flags} = {1'b1, calc, res, c, h, ld};
    @(negedge clk_i);
    alu_we = 1'b0;
    @(negedge clk_i);
    chk("flags", {11'h000, exp}, {11'h000, flags_o});
  endtask

  task automatic check_flags();
    flag_case(1'b0, 8'h00, 1'b0, 1'b0, 5'h15);
    flag_case(1'b1, 8'h00, 1'b1, 1'b0, 5'h00);
    flag_case(1'b1, 8'h81, 1'b0, 1'b1, 5'h00);
    flag_case(1'b1, 8'h07, 1'b0, 1'b0, 5'h1F);
    flag_case(1'b1, 8'h70, 1'b1, 1'b1, 5'h00);
  endtask

  task automatic run_program();
    int n;
    n = 0;
    while (unsupported_o !== 1'b1 && n < 3000) begin
      @(negedge clk_i);
      n++;
    end
    chk("halted", 16'h0001, {15'h0000, unsupported_o});
    chk("retired", 16'(n_ins), 16'(n_ret));
  endtask

  task automatic check_results();
    for (int i = 0; i < 5; i++) begin
      logic [2:0] r;
      r = (i == 4) ? 3'h7 : 3'(i);
      chk("reg_store", 16'h00A0 + 16'(r), {8'h00, cdt_mem_model_i.mem[16'h9000 + 16'(r)]});
    end
    chk("copy", 16'h003C, {8'h00, cdt_mem_model_i.mem[16'h9010]});
    chk("mem_read", 16'h00C3, {8'h00, cdt_mem_model_i.mem[16'h9021]});
    chk("imm_store", 16'h0077, {8'h00, cdt_mem_model_i.mem[16'h9030]});
    chk("dir_store", 16'h00A7, {8'h00, cdt_mem_model_i.mem[16'h9040]});
    chk("acc", 16'h0099, {8'h00, acc_o});
    chk("hl_load", 16'h0099, {8'h00, cdt_mem_model_i.mem[16'h1234]});
    chk("sp", 16'hBEEF, sp_o);
    chk("pair_lo", 16'h0066, {8'h00, cdt_mem_model_i.mem[16'h9070]});
    chk("pair_hi", 16'h0077, {8'h00, cdt_mem_model_i.mem[16'h9071]});
    chk("pc", 16'h0029, pc_o);
    chk("restart", 16'h0028, cdt_mem_model_i.last_rd);
    chk("flags_kept", 16'h0016, {11'h000, flags_o});
  endtask

  initial begin
    build_program();
    repeat (8) @(negedge clk_i);
    sys_rst_i = 1'b0;
    check_flags();
    flag_case(1'b0, 8'h00, 1'b0, 1'b0, 5'h16);
    run_program();
    check_results();
    final_report();
  end
endmodule
